// file: core/flc_cfg.sv
// Loop-2 configuration register bank with staged multiply update.
// Assumes a register master on ref_clk using one-cycle strobes; read data
// follow one cycle after the read strobe.
// What this block does
// - Holds 16-bit fractional numerator, reset 0x0018.
// - Numerator written while loop runs takes effect only on apply strobe.
// - Holds 16-bit fractional denominator, reset 0x007D.
// - Oscillator divider bits 11:8 divides by code plus one, reset 0.
// - Output divider bits 3:1 divides by code 2..7; 0,1 reserved; reset 6.
// - Reference prescaler bits 7:6 divides by 1,2,4,8; reset 00.
// - Both source selectors share one encoding at bits 3:0.
// - Unassigned source codes are reserved and select nothing.
// - Sync enable bit 0 switches synchroniser path on, reset zero.
// - Holds 10-bit sync integer multiply at bits 9:0, reset zero.
// - Holds 16-bit sync numerator and denominator, both reset zero.
// - Sync oscillator divider 1,2,4,8 for codes 0..3, 16 when top bit set.
// - Sync prescaler bits 7:6 divides by 1,2,4,8; reset 00.
// - Sync bandwidth bit 0: zero wide, one narrow; reset one.
// - Writing one to apply strobe moves pending multiply values into the loop.
// - 10-bit integer multiply, reset 8, applied only on strobe while enabled.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
module flc_cfg (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   output logic loop_enable,
   output logic [9:0] integer_mult,
   output logic [15:0] frac_numerator,
   output logic [15:0] frac_denominator,
   output logic [4:0] osc_divide_by,
   output logic [2:0] output_divider,
   output logic [3:0] ref_prescale_by,
   output logic [10:0] ref_source_onehot,
   output logic ref_source_reserved,
   output logic [8:0] loop_gain_factor,
   output logic sync_path_enable,
   output logic [9:0] sync_integer_mult,
   output logic [15:0] sync_frac_numerator,
   output logic [15:0] sync_frac_denominator,
   output logic [4:0] sync_osc_divide_by,
   output logic [3:0] sync_ref_prescale_by,
   output logic [10:0] sync_source_onehot,
   output logic sync_source_reserved,
   output logic [8:0] sync_loop_gain_factor,
   output logic sync_narrow_bandwidth
);
   // Software-visible fields
   logic loop_en_reg, loop_en_next;
   logic [9:0] int_pend_reg, int_pend_next;
   logic [15:0] num_pend_reg, num_pend_next;
   logic [9:0] int_run_reg, int_run_next;
   logic [15:0] num_run_reg, num_run_next;
   logic [15:0] den_reg, den_next;
   logic [3:0] osc_div_reg, osc_div_next;
   logic [2:0] out_div_reg, out_div_next;
   logic [1:0] pre_reg, pre_next;
   logic [3:0] src_reg, src_next;
   logic [3:0] gain_reg, gain_next;
   logic s_en_reg, s_en_next;
   logic [9:0] s_int_reg, s_int_next;
   logic [15:0] s_num_reg, s_num_next;
   logic [15:0] s_den_reg, s_den_next;
   logic [2:0] s_osc_reg, s_osc_next;
   logic [1:0] s_pre_reg, s_pre_next;
   logic [3:0] s_src_reg, s_src_next;
   logic [3:0] s_gain_reg, s_gain_next;
   logic s_bw_reg, s_bw_next;
   logic [15:0] rdata_reg, rdata_next;
   logic [10:0] src_oh, s_src_oh;
   logic src_rsv, s_src_rsv;
   logic [10:0] src_oh_reg, s_src_oh_reg;
   logic src_rsv_reg, s_src_rsv_reg;
   logic [4:0] osc_by_reg, osc_by_next;
   logic [4:0] s_osc_by_reg, s_osc_by_next;
   logic [3:0] pre_by_reg, pre_by_next;
   logic [3:0] s_pre_by_reg, s_pre_by_next;
   logic [8:0] gain_f_reg, gain_f_next;
   logic [8:0] s_gain_f_reg, s_gain_f_next;
   logic wr_int, apply;

   function automatic logic [8:0] gain_of(input logic [3:0] c);
      logic [8:0] g;
      g = 9'h000;
      if (c[3]) begin
         g = 9'h100;
      end else begin
         g = 9'(9'h001 << c[2:0]);
      end
      return g;
   endfunction : gain_of

   function automatic logic [3:0] pre_of(input logic [1:0] c);
      return 4'(4'h1 << c);
   endfunction : pre_of

   flc_src_decode u_src_main (
      .code(src_reg),
      .onehot(src_oh),
      .reserved(src_rsv)
   );

   flc_src_decode u_src_sync (
      .code(s_src_reg),
      .onehot(s_src_oh),
      .reserved(s_src_rsv)
   );

   assign wr_int = reg_write && (reg_addr == flc_pkg::OFS_INTEGER);
   // The strobe bit is write-only; it never stores and reads as zero
   assign apply = wr_int && reg_wdata[flc_pkg::UPD_BIT];

   always_comb begin
      loop_en_next = loop_en_reg;
      int_pend_next = int_pend_reg;
      num_pend_next = num_pend_reg;
      den_next = den_reg;
      osc_div_next = osc_div_reg;
      out_div_next = out_div_reg;
      pre_next = pre_reg;
      src_next = src_reg;
      gain_next = gain_reg;
      s_en_next = s_en_reg;
      s_int_next = s_int_reg;
      s_num_next = s_num_reg;
      s_den_next = s_den_reg;
      s_osc_next = s_osc_reg;
      s_pre_next = s_pre_reg;
      s_src_next = s_src_reg;
      s_gain_next = s_gain_reg;
      s_bw_next = s_bw_reg;
      if (reg_write) begin
         unique case (reg_addr)
            flc_pkg::OFS_LOOP_ENABLE: loop_en_next = reg_wdata[flc_pkg::ENA_BIT];
            flc_pkg::OFS_INTEGER: int_pend_next = reg_wdata[9:0];
            flc_pkg::OFS_FRAC_NUM: num_pend_next = reg_wdata;
            flc_pkg::OFS_FRAC_DEN: den_next = reg_wdata;
            flc_pkg::OFS_DIVIDERS: begin
               osc_div_next = reg_wdata[flc_pkg::OSCDIV_LSB +: 4];
               out_div_next = reg_wdata[flc_pkg::OUTDIV_LSB +: 3];
            end
            flc_pkg::OFS_REF_SEL: begin
               pre_next = reg_wdata[flc_pkg::PRESCALE_LSB +: 2];
               src_next = reg_wdata[3:0];
            end
            flc_pkg::OFS_GAIN: gain_next = reg_wdata[flc_pkg::GAIN_LSB +: 4];
            flc_pkg::OFS_SYNC_EN: s_en_next = reg_wdata[flc_pkg::ENA_BIT];
            flc_pkg::OFS_SYNC_INT: s_int_next = reg_wdata[9:0];
            flc_pkg::OFS_SYNC_NUM: s_num_next = reg_wdata;
            flc_pkg::OFS_SYNC_DEN: s_den_next = reg_wdata;
            flc_pkg::OFS_SYNC_DIV: s_osc_next = reg_wdata[flc_pkg::OSCDIV_LSB +: 3];
            flc_pkg::OFS_SYNC_REF: begin
               s_pre_next = reg_wdata[flc_pkg::PRESCALE_LSB +: 2];
               s_src_next = reg_wdata[3:0];
            end
            flc_pkg::OFS_SYNC_GBW: begin
               s_gain_next = reg_wdata[flc_pkg::GAIN_LSB +: 4];
               s_bw_next = reg_wdata[flc_pkg::BW_BIT];
            end
            default: ;
         endcase
      end
   end

   // Running multiply: follows the pending value while the loop is stopped,
   // so start-up uses the last written value; frozen while running until apply.
   always_comb begin
      int_run_next = int_run_reg;
      num_run_next = num_run_reg;
      if (!loop_en_reg) begin
         int_run_next = int_pend_next;
         num_run_next = num_pend_next;
      end else if (apply) begin
         int_run_next = reg_wdata[9:0];
         num_run_next = num_pend_reg;
      end
   end

   // Decoded divider and gain factors
   always_comb begin
      osc_by_next = 5'(osc_div_reg) + 5'h01;
      if (s_osc_reg[2]) begin
         s_osc_by_next = 5'h10;
      end else begin
         s_osc_by_next = 5'(5'h01 << s_osc_reg[1:0]);
      end
      pre_by_next = pre_of(pre_reg);
      s_pre_by_next = pre_of(s_pre_reg);
      gain_f_next = gain_of(gain_reg);
      s_gain_f_next = gain_of(s_gain_reg);
   end

   // Read mux; unassigned bits and unmapped offsets return zero
   always_comb begin
      rdata_next = 16'h0000;
      if (reg_read) begin
         unique case (reg_addr)
            flc_pkg::OFS_LOOP_ENABLE: rdata_next[flc_pkg::ENA_BIT] = loop_en_reg;
            flc_pkg::OFS_INTEGER: rdata_next[9:0] = int_pend_reg;
            flc_pkg::OFS_FRAC_NUM: rdata_next = num_pend_reg;
            flc_pkg::OFS_FRAC_DEN: rdata_next = den_reg;
            flc_pkg::OFS_DIVIDERS: begin
               rdata_next[flc_pkg::OSCDIV_LSB +: 4] = osc_div_reg;
               rdata_next[flc_pkg::OUTDIV_LSB +: 3] = out_div_reg;
            end
            flc_pkg::OFS_REF_SEL: begin
               rdata_next[flc_pkg::PRESCALE_LSB +: 2] = pre_reg;
               rdata_next[3:0] = src_reg;
            end
            flc_pkg::OFS_GAIN: rdata_next[flc_pkg::GAIN_LSB +: 4] = gain_reg;
            flc_pkg::OFS_SYNC_EN: rdata_next[flc_pkg::ENA_BIT] = s_en_reg;
            flc_pkg::OFS_SYNC_INT: rdata_next[9:0] = s_int_reg;
            flc_pkg::OFS_SYNC_NUM: rdata_next = s_num_reg;
            flc_pkg::OFS_SYNC_DEN: rdata_next = s_den_reg;
            flc_pkg::OFS_SYNC_DIV: rdata_next[flc_pkg::OSCDIV_LSB +: 3] = s_osc_reg;
            flc_pkg::OFS_SYNC_REF: begin
               rdata_next[flc_pkg::PRESCALE_LSB +: 2] = s_pre_reg;
               rdata_next[3:0] = s_src_reg;
            end
            flc_pkg::OFS_SYNC_GBW: begin
               rdata_next[flc_pkg::GAIN_LSB +: 4] = s_gain_reg;
               rdata_next[flc_pkg::BW_BIT] = s_bw_reg;
            end
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         loop_en_reg <= 1'b0;
         int_pend_reg <= flc_pkg::RST_INTEGER;
         num_pend_reg <= flc_pkg::RST_FRAC_NUM;
         int_run_reg <= flc_pkg::RST_INTEGER;
         num_run_reg <= flc_pkg::RST_FRAC_NUM;
         den_reg <= flc_pkg::RST_FRAC_DEN;
         osc_div_reg <= flc_pkg::RST_OSC_DIV;
         out_div_reg <= flc_pkg::RST_OUT_DIV;
         pre_reg <= flc_pkg::RST_PRESCALE;
         src_reg <= flc_pkg::RST_SOURCE;
         gain_reg <= flc_pkg::RST_GAIN;
         s_en_reg <= 1'b0;
         s_int_reg <= flc_pkg::RST_SYNC_INT;
         s_num_reg <= flc_pkg::RST_SYNC_WORD;
         s_den_reg <= flc_pkg::RST_SYNC_WORD;
         s_osc_reg <= flc_pkg::RST_SYNC_OSC;
         s_pre_reg <= flc_pkg::RST_PRESCALE;
         s_src_reg <= flc_pkg::RST_SOURCE;
         s_gain_reg <= flc_pkg::RST_GAIN;
         s_bw_reg <= flc_pkg::RST_SYNC_BW;
         rdata_reg <= 16'h0000;
         osc_by_reg <= 5'h01;
         s_osc_by_reg <= 5'h01;
         pre_by_reg <= 4'h1;
         s_pre_by_reg <= 4'h1;
         gain_f_reg <= 9'h001;
         s_gain_f_reg <= 9'h001;
         src_oh_reg <= 11'h001;
         s_src_oh_reg <= 11'h001;
         src_rsv_reg <= 1'b0;
         s_src_rsv_reg <= 1'b0;
      end else begin
         loop_en_reg <= loop_en_next;
         int_pend_reg <= int_pend_next;
         num_pend_reg <= num_pend_next;
         int_run_reg <= int_run_next;
         num_run_reg <= num_run_next;
         den_reg <= den_next;
         osc_div_reg <= osc_div_next;
         out_div_reg <= out_div_next;
         pre_reg <= pre_next;
         src_reg <= src_next;
         gain_reg <= gain_next;
         s_en_reg <= s_en_next;
         s_int_reg <= s_int_next;
         s_num_reg <= s_num_next;
         s_den_reg <= s_den_next;
         s_osc_reg <= s_osc_next;
         s_pre_reg <= s_pre_next;
         s_src_reg <= s_src_next;
         s_gain_reg <= s_gain_next;
         s_bw_reg <= s_bw_next;
         rdata_reg <= rdata_next;
         osc_by_reg <= osc_by_next;
         s_osc_by_reg <= s_osc_by_next;
         pre_by_reg <= pre_by_next;
         s_pre_by_reg <= s_pre_by_next;
         gain_f_reg <= gain_f_next;
         s_gain_f_reg <= s_gain_f_next;
         src_oh_reg <= src_oh;
         s_src_oh_reg <= s_src_oh;
         src_rsv_reg <= src_rsv;
         s_src_rsv_reg <= s_src_rsv;
      end
   end

   assign reg_rdata = rdata_reg;
   assign loop_enable = loop_en_reg;
   assign integer_mult = int_run_reg;
   assign frac_numerator = num_run_reg;
   assign frac_denominator = den_reg;
   assign osc_divide_by = osc_by_reg;
   // Reserved output-divider codes pass through unchanged; software must avoid them
   assign output_divider = out_div_reg;
   assign ref_prescale_by = pre_by_reg;
   assign ref_source_onehot = src_oh_reg;
   assign ref_source_reserved = src_rsv_reg;
   assign loop_gain_factor = gain_f_reg;
   assign sync_path_enable = s_en_reg;
   assign sync_integer_mult = s_int_reg;
   assign sync_frac_numerator = s_num_reg;
   assign sync_frac_denominator = s_den_reg;
   assign sync_osc_divide_by = s_osc_by_reg;
   assign sync_ref_prescale_by = s_pre_by_reg;
   assign sync_source_onehot = s_src_oh_reg;
   assign sync_source_reserved = s_src_rsv_reg;
   assign sync_loop_gain_factor = s_gain_f_reg;
   assign sync_narrow_bandwidth = s_bw_reg;
endmodule : flc_cfg

// file: core/flc_pkg.sv
// Package for the loop-2 configuration register bank.
// Assumes a 16-bit register word reached over a plain strobe port.
package flc_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 16;
   // Register offsets (word addresses)
   localparam logic [9:0] OFS_LOOP_ENABLE = 10'h191;
   localparam logic [9:0] OFS_INTEGER = 10'h192;
   localparam logic [9:0] OFS_FRAC_NUM = 10'h193;
   localparam logic [9:0] OFS_FRAC_DEN = 10'h194;
   localparam logic [9:0] OFS_DIVIDERS = 10'h195;
   localparam logic [9:0] OFS_REF_SEL = 10'h196;
   localparam logic [9:0] OFS_GAIN = 10'h199;
   localparam logic [9:0] OFS_SYNC_EN = 10'h1A1;
   localparam logic [9:0] OFS_SYNC_INT = 10'h1A2;
   localparam logic [9:0] OFS_SYNC_NUM = 10'h1A3;
   localparam logic [9:0] OFS_SYNC_DEN = 10'h1A4;
   localparam logic [9:0] OFS_SYNC_DIV = 10'h1A5;
   localparam logic [9:0] OFS_SYNC_REF = 10'h1A6;
   localparam logic [9:0] OFS_SYNC_GBW = 10'h1A7;
   // Field positions
   localparam int UPD_BIT = 15;
   localparam int ENA_BIT = 0;
   localparam int BW_BIT = 0;
   localparam int OSCDIV_LSB = 8;
   localparam int OUTDIV_LSB = 1;
   localparam int PRESCALE_LSB = 6;
   localparam int GAIN_LSB = 2;
   // Reset values
   localparam logic [15:0] RST_FRAC_NUM = 16'h0018;
   localparam logic [15:0] RST_FRAC_DEN = 16'h007D;
   localparam logic [9:0] RST_INTEGER = 10'h008;
   localparam logic [3:0] RST_OSC_DIV = 4'h0;
   localparam logic [2:0] RST_OUT_DIV = 3'h6;
   localparam logic [1:0] RST_PRESCALE = 2'h0;
   localparam logic [3:0] RST_SOURCE = 4'h0;
   localparam logic [3:0] RST_GAIN = 4'h0;
   localparam logic [15:0] RST_SYNC_WORD = 16'h0000;
   localparam logic [9:0] RST_SYNC_INT = 10'h000;
   localparam logic [2:0] RST_SYNC_OSC = 3'h0;
   localparam logic RST_SYNC_BW = 1'b1;
   // Source select encodings
   localparam logic [3:0] SRC_MCLK_A = 4'h0;
   localparam logic [3:0] SRC_MCLK_B = 4'h1;
   localparam logic [3:0] SRC_SERIAL = 4'h3;
   localparam logic [3:0] SRC_LOOP1 = 4'h4;
   localparam logic [3:0] SRC_LOOP2 = 4'h5;
   localparam logic [3:0] SRC_BCLK_A = 4'h8;
   localparam logic [3:0] SRC_BCLK_B = 4'h9;
   localparam logic [3:0] SRC_BCLK_C = 4'hA;
   localparam logic [3:0] SRC_FCLK_A = 4'hC;
   localparam logic [3:0] SRC_FCLK_B = 4'hD;
   localparam logic [3:0] SRC_FCLK_C = 4'hE;
   // One-hot source line count
   localparam int NUM_SRC = 11;
endpackage : flc_pkg

// file: core/flc_src_decode.sv
// Reference source decoder: turns a 4-bit select code into a one-hot line.
// Assumes a caller that registers the result; pure combinational.
`timescale 1ns/1ps
module flc_src_decode (
   input wire logic [3:0] code,
   output logic [10:0] onehot,
   output logic reserved
);
   always_comb begin
      onehot = 11'h000;
      reserved = 1'b0;
      unique case (code)
         flc_pkg::SRC_MCLK_A: onehot[0] = 1'b1;
         flc_pkg::SRC_MCLK_B: onehot[1] = 1'b1;
         flc_pkg::SRC_SERIAL: onehot[2] = 1'b1;
         flc_pkg::SRC_LOOP1: onehot[3] = 1'b1;
         flc_pkg::SRC_LOOP2: onehot[4] = 1'b1;
         flc_pkg::SRC_BCLK_A: onehot[5] = 1'b1;
         flc_pkg::SRC_BCLK_B: onehot[6] = 1'b1;
         flc_pkg::SRC_BCLK_C: onehot[7] = 1'b1;
         flc_pkg::SRC_FCLK_A: onehot[8] = 1'b1;
         flc_pkg::SRC_FCLK_B: onehot[9] = 1'b1;
         flc_pkg::SRC_FCLK_C: onehot[10] = 1'b1;
         // Reserved codes select nothing and raise a flag
         default: reserved = 1'b1;
      endcase
   end
endmodule : flc_src_decode

// file: dv/flc_cfg_bench.sv
// Self-checking bench for the loop-2 configuration bank.
// Assumes the bank is the only slave; the bench is the register master.
`timescale 1ns/1ps
module flc_cfg_bench;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [9:0] reg_addr = 10'h000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata, frac_numerator, frac_denominator;
   logic [15:0] sync_frac_numerator, sync_frac_denominator;
   logic loop_enable, ref_source_reserved, sync_path_enable;
   logic sync_source_reserved, sync_narrow_bandwidth;
   logic [9:0] integer_mult, sync_integer_mult;
   logic [4:0] osc_divide_by, sync_osc_divide_by;
   logic [2:0] output_divider;
   logic [3:0] ref_prescale_by, sync_ref_prescale_by;
   logic [10:0] ref_source_onehot, sync_source_onehot;
   logic [8:0] loop_gain_factor, sync_loop_gain_factor;
   int num_errors = 0;
   int samples_checked = 0;
   logic [15:0] sh [14];
   logic [15:0] snap, v, run_num;
   logic [9:0] run_int;
   logic [79:0] got_main, got_sync;
   logic [9:0] regs [14] = '{10'h191, 10'h192, 10'h193, 10'h194, 10'h195, 10'h196, 10'h199,
      10'h1A1, 10'h1A2, 10'h1A3, 10'h1A4, 10'h1A5, 10'h1A6, 10'h1A7};
   logic [15:0] msk [14] = '{16'h0001, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'h0F0E, 16'h00CF, 16'h003C,
      16'h0001, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'h0700, 16'h00CF, 16'h003D};
   logic [15:0] rst_words [14] = '{16'h0000, 16'h0008, 16'h0018, 16'h007D, 16'h000C, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
   logic [3:0] src_codes [11] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE};
   logic [9:0] holes [5] = '{10'h197, 10'h198, 10'h1A0, 10'h1A8, 10'h3FF};

   always #2.5 ref_clk = ~ref_clk;

   flc_cfg uut (
      .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .loop_enable,
      .integer_mult, .frac_numerator, .frac_denominator, .osc_divide_by, .output_divider,
      .ref_prescale_by, .ref_source_onehot, .ref_source_reserved, .loop_gain_factor,
      .sync_path_enable, .sync_integer_mult, .sync_frac_numerator, .sync_frac_denominator,
      .sync_osc_divide_by, .sync_ref_prescale_by, .sync_source_onehot, .sync_source_reserved,
      .sync_loop_gain_factor, .sync_narrow_bandwidth
   );

   // Reserved codes land on the flag bit above the one-hot lines
   function automatic logic [11:0] src_dec(input logic [3:0] c);
      src_dec = 12'h800;
      for (int k = 0; k < 11; k++)
         if (src_codes[k] == c)
            src_dec = 12'h001 << k;
   endfunction : src_dec

   function automatic logic [8:0] gain_dec(input logic [3:0] c);
      gain_dec = c[3] ? 9'h100 : 9'h001 << c[2:0];
   endfunction : gain_dec

   task automatic chk(input string what, input logic [79:0] e, input logic [79:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // One call per cycle, so no strobe is assigned twice at one edge
   task automatic acc(input logic w, input logic r, input logic [9:0] a, input logic [15:0] d);
      reg_write <= w;
      reg_read <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      snap = reg_rdata;
   endtask : acc

   task automatic wr(input int i, input logic [15:0] d);
      acc(1'b1, 1'b0, regs[i], d);
      sh[i] = d & msk[i];
      if (!sh[0][0] || (i == 1 && d[15])) begin
         run_int = sh[1][9:0];
         run_num = sh[2];
      end
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [15:0] d);
      acc(1'b0, 1'b1, a, 16'h0000);
      acc(1'b0, 1'b0, a, 16'h0000);
      d = snap;
   endtask : rd

   task automatic rd_all();
      for (int i = 0; i < 14; i++) begin
         rd(regs[i], v);
         chk("register word", sh[i], v);
      end
   endtask : rd_all

   // Two idle cycles cover the extra stage of the decoded outputs
   task automatic outs();
      acc(1'b0, 1'b0, 10'h000, 16'h0000);
      acc(1'b0, 1'b0, 10'h000, 16'h0000);
      got_main = 80'({loop_enable, integer_mult, frac_numerator, frac_denominator, osc_divide_by,
         output_divider, ref_prescale_by, ref_source_reserved, ref_source_onehot, loop_gain_factor});
      got_sync = 80'({sync_path_enable, sync_integer_mult, sync_frac_numerator,
         sync_frac_denominator, sync_osc_divide_by, sync_ref_prescale_by, sync_source_reserved,
         sync_source_onehot, sync_loop_gain_factor, sync_narrow_bandwidth});
      chk("main outputs", 80'({sh[0][0], run_int, run_num, sh[3], 5'(sh[4][11:8]) + 5'h01,
         sh[4][3:1], 4'h1 << sh[5][7:6], src_dec(sh[5][3:0]), gain_dec(sh[6][5:2])}),
         got_main);
      chk("sync outputs", 80'({sh[7][0], sh[8][9:0], sh[9], sh[10],
         sh[11][10] ? 5'h10 : 5'h01 << sh[11][9:8], 4'h1 << sh[12][7:6], src_dec(sh[12][3:0]),
         gain_dec(sh[13][5:2]), sh[13][0]}), got_sync);
   endtask : outs

   task automatic do_reset();
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      sh = rst_words;
      run_int = rst_words[1][9:0];
      run_num = rst_words[2];
   endtask : do_reset

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   initial begin
      void'($urandom(5886));
      do_reset();
      outs();
      rd_all();
      $display("reset values test done");
      for (int c = 0; c < 16; c++) begin
         for (int i = 3; i < 14; i++)
            wr(i, {4{4'(c)}});
         outs();
      end
      $display("code sweep test done");
      foreach (holes[k]) begin
         acc(1'b1, 1'b0, holes[k], 16'hFFFF);
         rd(holes[k], v);
         chk("unmapped read", 80'h0, 80'(v));
      end
      outs();
      rd_all();
      $display("unmapped test done");
      repeat (150) begin
         wr($urandom_range(13, 0), 16'($urandom));
         outs();
      end
      rd_all();
      $display("random test done");
      // Start-up order: stop, divide the reference by eight, configure, enable last
      wr(0, 16'h0000);
      wr(5, 16'h00C8);
      wr(2, 16'h1111);
      wr(1, 16'h0099);
      wr(0, 16'h0001);
      wr(2, 16'h4321);
      wr(1, 16'h0155);
      outs();
      wr(1, 16'h82AA);
      outs();
      rd_all();
      wr(0, 16'h0000);
      outs();
      $display("staged update test done");
      // Synchroniser start-up: path off, every other sync register, enable last
      wr(7, 16'h0000);
      for (int i = 8; i < 14; i++)
         wr(i, (i == 12) ? 16'h00C8 : 16'($urandom));
      wr(7, 16'h0001);
      outs();
      rd_all();
      $display("sync start test done");
      do_reset();
      outs();
      rd_all();
      $display("second reset test done");
      close_out();
   end

   // The tests need under 2000 cycles; ten times that marks a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      close_out();
   end
endmodule : flc_cfg_bench

// file: dv/flc_cfg_properties.sv
// Checker for the loop-2 configuration bank, bound to flc_cfg.
// Assumes a register master that never raises both strobes in one cycle.
`timescale 1ns/1ps
module flc_cfg_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic loop_enable,
   input wire logic [9:0] integer_mult,
   input wire logic [15:0] frac_numerator,
   input wire logic [15:0] frac_denominator,
   input wire logic [4:0] osc_divide_by,
   input wire logic [8:0] loop_gain_factor,
   input wire logic [10:0] ref_source_onehot,
   input wire logic ref_source_reserved,
   input wire logic [9:0] sync_integer_mult,
   input wire logic [4:0] sync_osc_divide_by,
   input wire logic sync_narrow_bandwidth
);
   logic apply_w;
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   assign apply_w = reg_write && reg_addr == flc_pkg::OFS_INTEGER && reg_wdata[15];
   sequence s_wr(logic [9:0] a);
      reg_write && reg_addr == a;
   endsequence
   sequence s_rd(logic [9:0] a);
      reg_read && reg_addr == a;
   endsequence
   a_rdata_quiet: assert property (!reg_read |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read reply");
   a_den_write: assert property (
      s_wr(flc_pkg::OFS_FRAC_DEN) |=> frac_denominator == $past(reg_wdata))
      else $error("denominator did not take the written word");
   a_den_readback: assert property (
      s_rd(flc_pkg::OFS_FRAC_DEN) |=> reg_rdata == frac_denominator)
      else $error("denominator read reply wrong");
   // Enable falling may let the running values follow the stored ones
   a_running_hold: assert property (loop_enable && !apply_w |=>
      !loop_enable || ($stable(frac_numerator) && $stable(integer_mult)))
      else $error("running multiply changed without apply");
   a_apply_moves: assert property (
      loop_enable && apply_w |=> integer_mult == $past(reg_wdata[9:0]))
      else $error("apply did not load integer multiply");
   a_sync_int: assert property (
      s_wr(flc_pkg::OFS_SYNC_INT) |=> sync_integer_mult == $past(reg_wdata[9:0]))
      else $error("sync integer multiply did not take the write");
   a_osc_decode: assert property (s_wr(flc_pkg::OFS_DIVIDERS) |-> ##2
      osc_divide_by == 5'($past(reg_wdata[11:8], 2)) + 5'h01)
      else $error("oscillator divide ratio wrong");
   a_gain_decode: assert property (s_wr(flc_pkg::OFS_GAIN) |-> ##2
      loop_gain_factor == ($past(reg_wdata[5], 2) ? 9'h100 : 9'h001 << $past(reg_wdata[4:2], 2)))
      else $error("loop gain factor wrong");
   a_sync_osc: assert property (s_wr(flc_pkg::OFS_SYNC_DIV) |-> ##2
      sync_osc_divide_by == ($past(reg_wdata[10], 2) ? 5'h10 : 5'h01 << $past(reg_wdata[9:8], 2)))
      else $error("sync oscillator divide wrong");
   a_src_frame_b: assert property (s_wr(flc_pkg::OFS_REF_SEL) |-> ##2
      (ref_source_onehot == 11'h200) == ($past(reg_wdata[3:0], 2) == 4'hD))
      else $error("frame clock b source decode wrong");
   a_src_reserved: assert property (s_wr(flc_pkg::OFS_REF_SEL) |-> ##2
      ref_source_reserved == ($past(reg_wdata[3:0], 2) inside {4'h2, 4'h6, 4'h7, 4'hB, 4'hF}))
      else $error("reserved source flag wrong");
   a_bw_write: assert property (
      s_wr(flc_pkg::OFS_SYNC_GBW) |=> sync_narrow_bandwidth == $past(reg_wdata[0]))
      else $error("bandwidth bit did not take the write");
endmodule : flc_cfg_checker

bind flc_cfg flc_cfg_checker chk_i (
   .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .loop_enable,
   .integer_mult, .frac_numerator, .frac_denominator, .osc_divide_by, .loop_gain_factor,
   .ref_source_onehot, .ref_source_reserved, .sync_integer_mult, .sync_osc_divide_by,
   .sync_narrow_bandwidth
);
